// ---- rtl/txsc_pkg.sv ----
package txsc_pkg;

	// register byte addresses
	localparam logic [7:0] TXSC_ADDR_ENABLES = 8'ha8;
	localparam logic [7:0] TXSC_ADDR_FRAME_CFG = 8'hb0;
	localparam logic [7:0] TXSC_ADDR_STATUS = 8'hc0;
	localparam logic [7:0] TXSC_ADDR_SLOT_COUNT = 8'hc4;

	// status and interrupt enable bit positions (shared layout)
	localparam int TXSC_BIT_UNDERRUN = 0;
	localparam int TXSC_BIT_EARLY_SYNC = 1;
	localparam int TXSC_BIT_CLOCK_FAIL = 2;
	localparam int TXSC_BIT_SLOT_PARITY = 3;
	localparam int TXSC_BIT_BUS_ERR = 7;
	localparam int TXSC_BIT_ANY_ERROR = 8;

	// frame configuration fields
	localparam int TXSC_FRAME_LEN_LSB = 0;
	localparam int TXSC_FRAME_LEN_W = 5;
	localparam int TXSC_BIT_BIPHASE = 8;

	// slot counter
	localparam int TXSC_SLOT_W = 10;
	localparam logic [9:0] TXSC_SLOT_LAST_BIPHASE = 10'h17f;
	localparam logic [9:0] TXSC_SLOT_RESET = 10'h17f;

	// values after reset
	localparam logic [4:0] TXSC_FRAME_LEN_M1_RESET = 5'h1f;
	localparam logic [7:0] TXSC_ENABLES_RESET = 8'h00;

	// bus answers
	localparam logic [1:0] TXSC_RESP_OKAY = 2'h0;
	localparam logic [1:0] TXSC_RESP_SLVERR = 2'h2;

endpackage : txsc_pkg

// ---- rtl/txsc_slot_counter.sv ----
// time-slot sequencer for the transmit section
module txsc_slot_counter (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic slotAdvance,
	input wire logic frameRestart,
	input wire logic biphase,
	input wire logic [4:0] frameLenM1,
	output logic [9:0] slotCount,
	output logic atFrameEnd
);

	typedef struct packed {
		logic [9:0] count;
	} txsc_slot_s;

	txsc_slot_s s_q;
	txsc_slot_s s_d;

	logic [9:0] lastSlot;

	// biphase blocks run the full 384 groups, multiplexed frames stop after frameLenM1 + 1 slots
	always_comb begin
		lastSlot = biphase ? txsc_pkg::TXSC_SLOT_LAST_BIPHASE : {5'h00, frameLenM1};
		atFrameEnd = (s_q.count == lastSlot);
		s_d = s_q;
		if (frameRestart && !biphase) begin
			s_d.count = 10'h000;
		end else if (slotAdvance) begin
			// the reset value 383 also wraps to zero, so the first group is slot 0
			if (atFrameEnd || (s_q.count == txsc_pkg::TXSC_SLOT_RESET)) begin
				s_d.count = 10'h000;
			end else begin
				s_d.count = s_q.count + 10'h001;
			end
		end
	end

	// counter held at 383 throughout reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '{count: txsc_pkg::TXSC_SLOT_RESET};
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	assign slotCount = s_q.count;

endmodule : txsc_slot_counter

// ---- rtl/txsc_tx_status.sv ----
// transmit status flags, interrupt and slot register behind an AXI4-Lite slave
module txsc_tx_status (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clkEn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// transmit section events
	input wire logic clockFailReport,
	input wire logic txFrameSync,
	input wire logic slotAdvance,
	input wire logic bufferMove,
	input wire logic bufferWritten,
	input wire logic busWriteError,
	// outputs
	output logic txInterrupt,
	output logic [9:0] txSlotCount
);

	// all state of the block except the sequencer's slot count in one record, registered by a single process
	typedef struct packed {
		// frame sync synchroniser and edge history
		logic fsMeta;
		logic fsSync;
		logic fsPrev;
		// captured write address and data, either may arrive first
		logic awHave;
		logic [7:0] awAddr;
		logic wHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		// bus handshake and answer registers
		logic awReady;
		logic wReady;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [1:0] rResp;
		logic [31:0] rData;
		// sticky error flags, cleared only by a write of one
		logic clockFail;
		logic earlySync;
		logic underrun;
		logic busErr;
		// software configuration
		logic [7:0] intEnables;
		logic [4:0] frameLenM1;
		logic biphase;
		// buffer tracking and registered outputs
		logic bufFull;
		logic irq;
		logic [9:0] slotMirror;
	} txsc_state_s;

	// all ready lines start high so a request may be taken at the first edge
	// after reset; the slot mirror starts at the parked count like the counter
	localparam txsc_state_s TXSC_STATE_RESET = '{
		awReady: 1'b1,
		wReady: 1'b1,
		arReady: 1'b1,
		intEnables: txsc_pkg::TXSC_ENABLES_RESET,
		frameLenM1: txsc_pkg::TXSC_FRAME_LEN_M1_RESET,
		slotMirror: txsc_pkg::TXSC_SLOT_RESET,
		default: '0
	};

	txsc_state_s s_q;
	txsc_state_s s_d;

	// sequencer outputs
	logic [9:0] slotCount;
	logic atFrameEnd;

	// decoded events of the current cycle
	logic syncEdge;
	logic earlyEvt;
	logic underrunEvt;
	logic doWrite;

	// register read and clear decode
	logic [31:0] statusWord;
	logic [31:0] readWord;
	logic readErr;
	logic [7:0] clearMask;
	logic [7:0] flagVec;

	// frame sync restarts the count; the sequencer keeps the slot, frame length and biphase come from the record
	// the restart is ignored in biphase mode, where blocks run on to 383
	txsc_slot_counter u_slot (
		.clock(clock),
		.arst_n(arst_n),
		.clkEn(clkEn),
		.slotAdvance(slotAdvance),
		.frameRestart(syncEdge),
		.biphase(s_q.biphase),
		.frameLenM1(s_q.frameLenM1),
		.slotCount(slotCount),
		.atFrameEnd(atFrameEnd)
	);

	// status word assembly; bits not held here read as zero
	// the summary bit follows the flags combinationally, so it never lags them
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[txsc_pkg::TXSC_BIT_UNDERRUN] = s_q.underrun;
		statusWord[txsc_pkg::TXSC_BIT_EARLY_SYNC] = s_q.earlySync;
		statusWord[txsc_pkg::TXSC_BIT_CLOCK_FAIL] = s_q.clockFail;
		statusWord[txsc_pkg::TXSC_BIT_SLOT_PARITY] = slotCount[0];
		statusWord[txsc_pkg::TXSC_BIT_BUS_ERR] = s_q.busErr;
		statusWord[txsc_pkg::TXSC_BIT_ANY_ERROR] =
			s_q.underrun | s_q.earlySync | s_q.clockFail | s_q.busErr;
	end

	// read decode
	// the word is taken into the read data register at the address handshake
	always_comb begin
		readWord = 32'h0000_0000;
		readErr = 1'b0;
		case (s_axi_araddr)
			txsc_pkg::TXSC_ADDR_STATUS: begin
				readWord = statusWord;
			end
			txsc_pkg::TXSC_ADDR_SLOT_COUNT: begin
				readWord = {22'h000000, slotCount};
			end
			txsc_pkg::TXSC_ADDR_ENABLES: begin
				readWord = {24'h000000, s_q.intEnables};
			end
			txsc_pkg::TXSC_ADDR_FRAME_CFG: begin
				readWord[txsc_pkg::TXSC_BIT_BIPHASE] = s_q.biphase;
				readWord[txsc_pkg::TXSC_FRAME_LEN_LSB +: txsc_pkg::TXSC_FRAME_LEN_W] =
					s_q.frameLenM1;
			end
			default: begin
				// unmapped addresses answer with an error and zero data
				readErr = 1'b1;
			end
		endcase
	end

	// event detection
	always_comb begin
		// the edge is taken from the synchronised copy, never from the raw pin
		syncEdge = s_q.fsSync & ~s_q.fsPrev;
		// a sync before the last slot of the frame is early; the count parked at
		// 383 after reset means no frame is running yet, so nothing is early
		earlyEvt = syncEdge & ~s_q.biphase & ~atFrameEnd
			& (slotCount != txsc_pkg::TXSC_SLOT_RESET);
		// a refill in the same cycle as the move counts as serviced
		underrunEvt = bufferMove & ~s_q.bufFull & ~bufferWritten;
		// a write is applied once both halves are held and no response is pending
		doWrite = s_q.awHave & s_q.wHave & ~s_q.bValid;
	end

	// write-one-to-clear mask for the status flags, byte lane 0 only
	// bits 3 and 8 are computed, so writes to them have no effect
	always_comb begin
		clearMask = 8'h00;
		if (doWrite && (s_q.awAddr == txsc_pkg::TXSC_ADDR_STATUS) && s_q.wStrb[0]) begin
			clearMask = s_q.wData[7:0];
		end
	end

	// next state
	always_comb begin
		s_d = s_q;

		// two-flop synchroniser on the frame sync pin, then edge history
		s_d.fsMeta = txFrameSync;
		s_d.fsSync = s_q.fsMeta;
		s_d.fsPrev = s_q.fsSync;

		// write address and data channels, taken in either order
		if (s_axi_awvalid && s_q.awReady) begin
			s_d.awHave = 1'b1;
			s_d.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wReady) begin
			s_d.wHave = 1'b1;
			s_d.wData = s_axi_wdata;
			s_d.wStrb = s_axi_wstrb;
		end
		if (doWrite) begin
			// both halves held: apply the write and raise the response together
			s_d.awHave = 1'b0;
			s_d.wHave = 1'b0;
			s_d.bValid = 1'b1;
			s_d.bResp = txsc_pkg::TXSC_RESP_OKAY;
			case (s_q.awAddr)
				txsc_pkg::TXSC_ADDR_ENABLES: begin
					if (s_q.wStrb[0]) begin
						s_d.intEnables = s_q.wData[7:0];
					end
				end
				txsc_pkg::TXSC_ADDR_FRAME_CFG: begin
					if (s_q.wStrb[0]) begin
						s_d.frameLenM1 =
							s_q.wData[txsc_pkg::TXSC_FRAME_LEN_LSB +: txsc_pkg::TXSC_FRAME_LEN_W];
					end
					if (s_q.wStrb[1]) begin
						s_d.biphase = s_q.wData[txsc_pkg::TXSC_BIT_BIPHASE];
					end
				end
				// status clears through clearMask; slot count ignores the data
				txsc_pkg::TXSC_ADDR_STATUS: begin
					s_d.bResp = txsc_pkg::TXSC_RESP_OKAY;
				end
				txsc_pkg::TXSC_ADDR_SLOT_COUNT: begin
					s_d.bResp = txsc_pkg::TXSC_RESP_OKAY;
				end
				default: begin
					s_d.bResp = txsc_pkg::TXSC_RESP_SLVERR;
				end
			endcase
		end
		// the response stands until the master takes it
		if (s_q.bValid && s_axi_bready) begin
			s_d.bValid = 1'b0;
		end
		// one write at a time: both channels stay closed until the response is taken
		s_d.awReady = ~s_d.awHave & ~s_d.bValid;
		s_d.wReady = ~s_d.wHave & ~s_d.bValid;

		// read channel: answer one cycle after the address is taken
		if (s_axi_arvalid && s_q.arReady) begin
			s_d.arReady = 1'b0;
			s_d.rValid = 1'b1;
			s_d.rData = readWord;
			s_d.rResp = readErr ? txsc_pkg::TXSC_RESP_SLVERR : txsc_pkg::TXSC_RESP_OKAY;
		end
		// reopen the address channel only after the data has been taken
		if (s_q.rValid && s_axi_rready) begin
			s_d.rValid = 1'b0;
			s_d.arReady = 1'b1;
		end

		// holding buffer occupancy, for underrun detection
		// a refill together with a move leaves the buffer full for the next move
		s_d.bufFull = bufferWritten | (s_q.bufFull & ~bufferMove);

		// sticky flags: a new event wins over a clear in the same cycle
		// each flag holds until a one is written to its position
		s_d.clockFail = clockFailReport
			| (s_q.clockFail & ~clearMask[txsc_pkg::TXSC_BIT_CLOCK_FAIL]);
		s_d.earlySync = earlyEvt
			| (s_q.earlySync & ~clearMask[txsc_pkg::TXSC_BIT_EARLY_SYNC]);
		s_d.underrun = underrunEvt
			| (s_q.underrun & ~clearMask[txsc_pkg::TXSC_BIT_UNDERRUN]);
		s_d.busErr = busWriteError
			| (s_q.busErr & ~clearMask[txsc_pkg::TXSC_BIT_BUS_ERR]);

		// interrupt from the next-state flags, gated by the next-state enables
		// using the next-state values saves a cycle of interrupt latency
		flagVec = 8'h00;
		flagVec[txsc_pkg::TXSC_BIT_CLOCK_FAIL] = s_d.clockFail;
		flagVec[txsc_pkg::TXSC_BIT_EARLY_SYNC] = s_d.earlySync;
		flagVec[txsc_pkg::TXSC_BIT_UNDERRUN] = s_d.underrun;
		flagVec[txsc_pkg::TXSC_BIT_BUS_ERR] = s_d.busErr;
		s_d.irq = |(flagVec & s_d.intEnables);

		// registered copy so the slot output comes from a flip-flop
		s_d.slotMirror = slotCount;
	end

	// single state register; the clock enable freezes everything
	// the reset branch loads only the constant record, never live inputs
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= TXSC_STATE_RESET;
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	// outputs are plain views of register fields, no logic after the flops
	assign s_axi_awready = s_q.awReady;
	assign s_axi_wready = s_q.wReady;
	assign s_axi_bvalid = s_q.bValid;
	assign s_axi_bresp = s_q.bResp;
	assign s_axi_arready = s_q.arReady;
	assign s_axi_rvalid = s_q.rValid;
	assign s_axi_rdata = s_q.rData;
	assign s_axi_rresp = s_q.rResp;
	assign txInterrupt = s_q.irq;
	assign txSlotCount = s_q.slotMirror;

endmodule : txsc_tx_status

// ---- tb/txsc_tx_status_assertions.sv ----
// port-level checks, one clock domain
module txsc_tx_status_assertions (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic slotAdvance,
	input wire logic [9:0] txSlotCount,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	// slot count: reset value, range, single steps, wrap after 383
	property p_rst; $rose(arst_n) |-> txSlotCount == 10'h17f; endproperty
	a_rst: assert property (p_rst) else $error("slot reset");
	property p_rng; txSlotCount <= 10'h17f; endproperty
	a_rng: assert property (p_rng) else $error("slot range");
	property p_step; txSlotCount != $past(txSlotCount) |->
		txSlotCount == 10'h0 || txSlotCount == $past(txSlotCount) + 10'h1; endproperty
	a_step: assert property (p_step) else $error("slot step");
	property p_wrap; slotAdvance ##1 txSlotCount == 10'h17f |=> txSlotCount == 10'h0; endproperty
	a_wrap: assert property (p_wrap) else $error("slot wrap");
	// register access timing; tb offers address and data together
	property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read answer");
	property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rbusy: assert property (p_rbusy) else $error("read overlap");
	property p_wr; s_axi_awvalid && s_axi_awready |-> ##2 s_axi_bvalid; endproperty
	a_wr: assert property (p_wr) else $error("write answer");
	property p_wbusy; s_axi_bvalid |-> !s_axi_awready; endproperty
	a_wbusy: assert property (p_wbusy) else $error("write overlap");
	c_rd: cover property (s_axi_rvalid);
	c_wr: cover property (s_axi_bvalid);
	c_wrap: cover property (slotAdvance ##1 txSlotCount == 10'h17f);
endmodule : txsc_tx_status_assertions

bind txsc_tx_status txsc_tx_status_assertions u_chk (.clock, .arst_n, .slotAdvance,
	.txSlotCount, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid);

// ---- tb/txsc_codec_model.sv ----
// far-side codec: sync line idles low, one wide pulse per request
module txsc_codec_model (
	input wire logic clock,
	input wire logic fire,
	output logic frameSync
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] left_q = 3'h0;
	// pulse spans several clocks so the pin synchroniser cannot miss it
	always_ff @(posedge clock) begin
		if (fire) left_q <= 3'h4;
		else if (left_q != 3'h0) left_q <= left_q - 3'h1;
	end
	assign frameSync = (left_q != 3'h0);
endmodule : txsc_codec_model

// ---- tb/txsc_tx_status_tb.sv ----
module txsc_tx_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] ST = txsc_pkg::TXSC_ADDR_STATUS;
	localparam logic [7:0] SL = txsc_pkg::TXSC_ADDR_SLOT_COUNT;
	localparam logic [7:0] EN = txsc_pkg::TXSC_ADDR_ENABLES;
	localparam logic [7:0] FC = txsc_pkg::TXSC_ADDR_FRAME_CFG;
	localparam logic [1:0] OK = txsc_pkg::TXSC_RESP_OKAY;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fire = 1'b0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [4:0] ev = 5'h0; // slot, bus error, refill, move, clock fail
	logic txInterrupt, txFrameSync;
	logic [9:0] txSlotCount;
	int badCount = 0, numChecks = 0, cycles = 0;
	initial forever #20 clock = ~clock;
	txsc_codec_model codec (.clock, .fire, .frameSync(txFrameSync));
	txsc_tx_status dut (.clock, .arst_n, .clkEn(1'b1), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.clockFailReport(ev[0]), .bufferMove(ev[1]), .bufferWritten(ev[2]),
		.busWriteError(ev[3]), .slotAdvance(ev[4]), .txFrameSync, .txInterrupt, .txSlotCount);
	task automatic endSim();
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : endSim
	// a hung handshake ends the run as a failure
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			badCount++;
			endSim();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			badCount++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// bus master: payload held until each channel is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = OK,
		input logic [3:0] s = 4'hf);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, r});
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = OK);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, {30'h0, r});
	endtask : rdc
	// one-cycle event pulses, repeated n times
	task automatic pulse(input logic [4:0] m, input int n);
		repeat (n) begin
			@(posedge clock);
			ev <= m;
			@(posedge clock);
			ev <= 5'h0;
		end
	endtask : pulse
	// settle margin covers the one-edge interrupt delay
	task automatic irqIs(input logic e);
		repeat (2) @(posedge clock);
		chk({31'h0, txInterrupt}, {31'h0, e});
	endtask : irqIs
	task automatic syncPulse();
		@(posedge clock);
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		repeat (8) @(posedge clock);
	endtask : syncPulse
	task automatic tReset();
		rdc(SL, 32'h17f);
		chk({22'h0, txSlotCount}, 32'h17f);
		rdc(ST, 32'h8);
		rdc(EN, 32'h0);
		rdc(FC, 32'h1f);
		rdc(8'h10, 32'h0, txsc_pkg::TXSC_RESP_SLVERR);
		wr(8'h10, 32'hffffffff, txsc_pkg::TXSC_RESP_SLVERR);
	endtask : tReset
	task automatic tUnderrun();
		pulse(5'h04, 1);
		pulse(5'h02, 1);
		rdc(ST, 32'h8);
		pulse(5'h02, 1);
		rdc(ST, 32'h109);
		irqIs(1'b0);
		wr(EN, 32'h1);
		irqIs(1'b1);
		wr(ST, 32'h0);
		rdc(ST, 32'h109);
		wr(ST, 32'h1);
		irqIs(1'b0);
		wr(EN, 32'h0);
	endtask : tUnderrun
	task automatic tFlags();
		pulse(5'h01, 1);
		rdc(ST, 32'h10c);
		wr(EN, 32'h4);
		irqIs(1'b1);
		wr(ST, 32'h4);
		irqIs(1'b0);
		pulse(5'h08, 1);
		rdc(ST, 32'h188);
		wr(ST, 32'h80);
		rdc(ST, 32'h8);
	endtask : tFlags
	// early sync inside a frame, then an expected one at the frame end
	task automatic tSync();
		pulse(5'h10, 2);
		rdc(SL, 32'h1);
		syncPulse();
		rdc(ST, 32'h102);
		wr(EN, 32'h2);
		irqIs(1'b1);
		wr(ST, 32'h2);
		pulse(5'h10, 31);
		rdc(SL, 32'h1f);
		syncPulse();
		rdc(ST, 32'h0);
		pulse(5'h10, 32);
		rdc(SL, 32'h0);
		wr(EN, 32'h0);
	endtask : tSync
	task automatic tBiphase();
		wr(FC, 32'h10f, OK, 4'h1);
		rdc(FC, 32'hf);
		wr(FC, 32'h11f);
		pulse(5'h10, 383);
		rdc(SL, 32'h17f);
		chk({22'h0, txSlotCount}, 32'h17f);
		wr(SL, 32'hffffffff);
		rdc(SL, 32'h17f);
		rdc(ST, 32'h8);
		pulse(5'h10, 1);
		rdc(SL, 32'h0);
	endtask : tBiphase
	initial begin
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		tReset();
		tUnderrun();
		tFlags();
		tSync();
		tBiphase();
		endSim();
	end
endmodule : txsc_tx_status_tb
